// >>> core/speed_ref_zero.sv
// speed reference selection (multispeed, e-pot) and zero-speed disable
// assumes din comes from isolated pins; other inputs are on pclk
`timescale 1ns/1ps
`include "speed_ref_params.svh"

// Operation
// - eight stored fixed speed references
// - select bits form index, input2 most significant
// - unassigned select input counts as zero
// - multispeed drives reference when source is eight
// - select input counts only with function thirteen
// - e-pot drives reference when source is seven
// - function eleven increases, twelve decreases
// - raise while increase high, lower while decrease low
// - disabled with both inputs active resets e-pot
// - mode one: reference and speed low disable
// - mode two: reference low alone disables
// - exit on reference or speed, or reference only
// - regulator in auto also needs wake error
// - zero delay immediate, else timer then disable
// - condition lost while timing clears timer
// - enabled drive clamps reference to limits
module speed_ref_zero
	import speed_ref_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `DELAY_UNIT_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// isolated digital inputs, bits 0..2 are speed_select_in_0..2
	input  wire logic [`N_DIN-1:0] din,
	// drive side, same clock
	input  wire logic              drive_run_cmd,
	input  wire logic [`SPD_W-1:0] ref_other,
	input  wire logic [`SPD_W-1:0] actual_speed_value,
	input  wire logic [`SPD_W-1:0] regulator_error,
	output logic      [`SPD_W-1:0] speed_ref_value,
	output logic                   drive_enable,
	output logic                   zero_speed_disable
);

	localparam logic [`TICK_W-1:0] TICK_LAST = `TICK_W'(TICK_CYCLES - 1);

	state_t s_q;
	state_t s_d;

	function automatic logic fn_any(input logic [`N_DIN-1:0] lv,
			input logic [`N_DIN-1:0][`FN_W-1:0] f, input logic [`FN_W-1:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < `N_DIN; i++) begin
			r = r | (lv[i] & (f[i] == code));
		end
		return r;
	endfunction : fn_any

	function automatic logic [2:0] ms_index(input logic [`N_DIN-1:0] lv,
			input logic [`N_DIN-1:0][`FN_W-1:0] f);
		logic [2:0] r;
		for (int b = 0; b < 3; b++) begin
			r[b] = lv[b] & (f[b] == `FN_MS);
		end
		return r;
	endfunction : ms_index

	function automatic logic reg_hit(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= `A_FIXED_LAST);
	endfunction : reg_hit

	logic [`SRC_W-1:0] src;
	logic [2:0]        ms_idx;
	logic              ep_up;
	logic              ep_dn;
	logic              ep_tick;
	logic [`SPD_W-1:0] sel_ref;
	logic [`SPD_W:0]   ep_sum;
	logic [`SPD_W:0]   ep_floor;
	logic [`SPD_W-1:0] hyst;
	logic [`SPD_W-1:0] thr_lo;
	logic [`SPD_W:0]   thr_hi;
	logic              enter_c;
	logic              exit_c;
	logic [1:0]        zmode;

	always_comb begin
		src      = s_q.ctrl[`C_REM_SEL] ? s_q.ctrl[`C_REM +: `SRC_W] : s_q.ctrl[`C_LOC +: `SRC_W];
		ms_idx   = ms_index(s_q.din_s2, s_q.din_func);
		ep_up    = fn_any(s_q.din_s2, s_q.din_func, `FN_EP_UP);
		// decrease input is active when low
		ep_dn    = fn_any(~s_q.din_s2, s_q.din_func, `FN_EP_DN);
		ep_tick  = s_q.ep_cnt >= s_q.ep_div;
		ep_sum   = {1'b0, s_q.ep_ref} + {1'b0, s_q.ep_step};
		ep_floor = {1'b0, s_q.min_lim} + {1'b0, s_q.ep_step};
		zmode    = s_q.ctrl[`C_ZS_MODE +: 2];
		unique case (src)
			`SRC_MS: sel_ref = s_q.fixed[ms_idx];
			`SRC_EP: sel_ref = s_q.ep_ref;
			default: sel_ref = ref_other;
		endcase
		hyst   = s_q.rated / `HYST_DIV;
		thr_lo = (s_q.thresh > hyst) ? s_q.thresh - hyst : '0;
		thr_hi = {1'b0, s_q.thresh} + {1'b0, hyst};
		unique case (zmode)
			`MODE_BOTH: enter_c = (sel_ref < thr_lo) && (actual_speed_value < thr_lo);
			`MODE_REF:  enter_c = sel_ref < thr_lo;
			default:    enter_c = 1'b0;
		endcase
		exit_c = ({1'b0, sel_ref} > thr_hi)
			|| (!s_q.ctrl[`C_EXIT] && ({1'b0, actual_speed_value} > thr_hi));
		if (s_q.ctrl[`C_REG_SEL] && s_q.ctrl[`C_REG_AUTO]) begin
			exit_c = exit_c && (regulator_error > s_q.wake);
		end
	end

	always_comb begin
		s_d        = s_q;
		s_d.din_s1 = din;
		s_d.din_s2 = s_q.din_s1;

		// clamp only while enabled; max wins if limits cross
		s_d.spd_ref = sel_ref;
		if (s_q.drv_en) begin
			if (sel_ref < s_q.min_lim) begin
				s_d.spd_ref = s_q.min_lim;
			end
			if (sel_ref > s_q.max_lim) begin
				s_d.spd_ref = s_q.max_lim;
			end
		end

		// e-pot rate divider
		s_d.ep_cnt = ep_tick ? '0 : s_q.ep_cnt + 1'b1;
		if (!s_q.drv_en && ep_up && ep_dn) begin
			s_d.ep_ref = s_q.min_lim;
		end else if (ep_tick && ep_up && !ep_dn) begin
			s_d.ep_ref = (ep_sum > {1'b0, s_q.max_lim}) ? s_q.max_lim : ep_sum[`SPD_W-1:0];
		end else if (ep_tick && ep_dn && !ep_up) begin
			s_d.ep_ref = ({1'b0, s_q.ep_ref} < ep_floor) ? s_q.min_lim : s_q.ep_ref - s_q.ep_step;
		end

		// zero-speed disable
		unique case (s_q.zs)
			ZS_RUN: begin
				s_d.tick_cnt = '0;
				s_d.sec_cnt  = '0;
				if (enter_c) begin
					s_d.zs = (s_q.zs_delay == '0) ? ZS_DIS : ZS_TIMING;
				end
			end
			ZS_TIMING: begin
				if (!enter_c) begin
					s_d.zs       = ZS_RUN;
					s_d.tick_cnt = '0;
					s_d.sec_cnt  = '0;
				end else if (s_q.tick_cnt == TICK_LAST) begin
					s_d.tick_cnt = '0;
					s_d.sec_cnt  = s_q.sec_cnt + 1'b1;
					if (s_q.sec_cnt + 1'b1 >= s_q.zs_delay) begin
						s_d.zs = ZS_DIS;
					end
				end else begin
					s_d.tick_cnt = s_q.tick_cnt + 1'b1;
				end
			end
			ZS_DIS: begin
				if (exit_c) begin
					s_d.zs = ZS_RUN;
				end
			end
			default: s_d.zs = ZS_RUN;
		endcase
		if (zmode == `MODE_OFF) begin
			s_d.zs       = ZS_RUN;
			s_d.tick_cnt = '0;
			s_d.sec_cnt  = '0;
		end
		s_d.zs_dis = s_d.zs == ZS_DIS;
		s_d.drv_en = drive_run_cmd && (s_d.zs != ZS_DIS);

		// apb: answer in the first access cycle, no wait states
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		if (psel && !penable) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = !reg_hit(paddr);
			s_d.prdata  = '0;
			// refused addresses fall to the case default and read zero
			if (reg_hit(paddr) && paddr >= `A_FIXED_BASE) begin
				s_d.prdata[`SPD_W-1:0] = s_q.fixed[paddr[4:2]];
			end else begin
				unique case (paddr)
					`A_CTRL:     s_d.prdata[`CTRL_W-1:0] = s_q.ctrl;
					`A_DIN_FUNC: s_d.prdata[`N_DIN*`FN_W-1:0] = s_q.din_func;
					`A_DELAY:    s_d.prdata[`DELAY_W-1:0] = s_q.zs_delay;
					`A_THRESH:   s_d.prdata = {s_q.rated, s_q.thresh};
					`A_LIMITS:   s_d.prdata = {s_q.max_lim, s_q.min_lim};
					`A_EP:       s_d.prdata = {s_q.ep_div, s_q.ep_step};
					`A_WAKE:     s_d.prdata[`SPD_W-1:0] = s_q.wake;
					`A_STATUS: begin
						s_d.prdata[`SPD_W-1:0]   = s_q.spd_ref;
						s_d.prdata[`S_DRV_EN]    = s_q.drv_en;
						s_d.prdata[`S_ZS_DIS]    = s_q.zs_dis;
						s_d.prdata[`S_ZS_TIMING] = s_q.zs == ZS_TIMING;
					end
					default: s_d.prdata = '0;
				endcase
			end
		end
		if (psel && penable && s_q.pready && pwrite && reg_hit(paddr)) begin
			if (paddr >= `A_FIXED_BASE) begin
				s_d.fixed[paddr[4:2]] = pwdata[`SPD_W-1:0];
			end else begin
				unique case (paddr)
					`A_CTRL:     s_d.ctrl = pwdata[`CTRL_W-1:0];
					`A_DIN_FUNC: s_d.din_func = pwdata[`N_DIN*`FN_W-1:0];
					`A_DELAY:    s_d.zs_delay = pwdata[`DELAY_W-1:0];
					`A_THRESH:   {s_d.rated, s_d.thresh} = pwdata;
					`A_LIMITS:   {s_d.max_lim, s_d.min_lim} = pwdata;
					`A_EP:       {s_d.ep_div, s_d.ep_step} = pwdata;
					`A_WAKE:     s_d.wake = pwdata[`SPD_W-1:0];
					default: ; // status is read only
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q          <= '0;
			s_q.rated    <= `RST_RATED;
			s_q.thresh   <= `RST_THRESH;
			s_q.min_lim  <= `RST_MIN;
			s_q.max_lim  <= `RST_MAX;
			s_q.ep_step  <= `RST_EP_STEP;
			s_q.ep_div   <= `RST_EP_DIV;
			s_q.ep_ref   <= `RST_MIN;
			s_q.fixed    <= {`RST_FIX7, `RST_FIX6, `RST_FIX5, `RST_FIX4,
				`RST_FIX3, `RST_FIX2, `RST_FIX1, `RST_FIX0};
			s_q.zs       <= ZS_RUN;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign prdata             = s_q.prdata;
	assign pready             = s_q.pready;
	assign pslverr            = s_q.pslverr;
	assign speed_ref_value    = s_q.spd_ref;
	assign drive_enable       = s_q.drv_en;
	assign zero_speed_disable = s_q.zs_dis;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ms_index: assert property (
		ce && src == `SRC_MS && !s_q.drv_en |=> !ce || s_q.spd_ref == $past(s_q.fixed[ms_idx])
	) else $error("multispeed output not the indexed reference");

	a_unassigned_zero: assert property (
		s_q.din_func[0] != `FN_MS && s_q.din_func[1] != `FN_MS |-> ms_idx[1:0] == 2'b00
	) else $error("unassigned select input counted");

	a_ep_reset: assert property (
		ce && !s_q.drv_en && ep_up && ep_dn |=> !ce || s_q.ep_ref == $past(s_q.min_lim)
	) else $error("e-pot not reset while disabled");

	a_ep_raise: assert property (
		ce && ep_tick && ep_up && !ep_dn && s_q.drv_en && s_q.ep_ref < s_q.max_lim && s_q.ep_step != '0
		|=> !ce || s_q.ep_ref > $past(s_q.ep_ref)
	) else $error("e-pot did not rise");

	a_zs_off: assert property (
		ce && zmode == `MODE_OFF |=> !ce || (s_q.zs == ZS_RUN && !zero_speed_disable)
	) else $error("zero-speed active with mode off");

	a_zs_nodelay: assert property (
		ce && s_q.zs == ZS_RUN && enter_c && s_q.zs_delay == '0 |=> !ce || zero_speed_disable
	) else $error("undelayed zero-speed disable missed");

	a_timer_clear: assert property (
		ce && s_q.zs == ZS_TIMING && !enter_c
		|=> !ce || (s_q.zs == ZS_RUN && s_q.sec_cnt == '0 && drive_enable == $past(drive_run_cmd))
	) else $error("timer not cleared on lost condition");

	a_zs_hold: assert property (
		ce && s_q.zs == ZS_DIS && zmode != `MODE_OFF && !exit_c |=> !ce || (zero_speed_disable && !drive_enable)
	) else $error("zero-speed disable left without exit");

	a_clamp_limits: assert property (
		drive_enable && $stable(s_q.min_lim) && $stable(s_q.max_lim) && s_q.min_lim <= s_q.max_lim
		&& $past(s_q.drv_en)
		|-> speed_ref_value >= s_q.min_lim && speed_ref_value <= s_q.max_lim
	) else $error("enabled reference outside limits");

	a_ep_select: assert property (
		ce && src == `SRC_EP && !s_q.drv_en |=> !ce || s_q.spd_ref == $past(s_q.ep_ref)
	) else $error("e-pot source not driving the reference");

	a_ep_lower: assert property (
		ce && ep_tick && ep_dn && !ep_up && s_q.drv_en && s_q.ep_step != '0 && s_q.ep_ref > s_q.min_lim
		|=> !ce || s_q.ep_ref < $past(s_q.ep_ref)
	) else $error("e-pot did not fall");

	a_ref_enter: assert property (
		ce && s_q.zs == ZS_RUN && zmode == `MODE_REF && sel_ref < thr_lo && s_q.zs_delay == '0
		|=> !ce || (zero_speed_disable && !drive_enable)
	) else $error("low reference did not disable");

	a_speed_needed: assert property (
		ce && s_q.zs == ZS_RUN && zmode == `MODE_BOTH && actual_speed_value >= thr_lo
		|=> !ce || !zero_speed_disable
	) else $error("disabled while actual speed high");

	a_exit_ref_only: assert property (
		ce && s_q.zs == ZS_DIS && zmode != `MODE_OFF && s_q.ctrl[`C_EXIT] && {1'b0, sel_ref} <= thr_hi
		|=> !ce || zero_speed_disable
	) else $error("left disable without reference above threshold");

	a_wake_needed: assert property (
		ce && s_q.zs == ZS_DIS && zmode != `MODE_OFF && s_q.ctrl[`C_REG_SEL] && s_q.ctrl[`C_REG_AUTO]
		&& regulator_error <= s_q.wake |=> !ce || zero_speed_disable
	) else $error("left disable without regulator wake error");

	a_delay_wait: assert property (
		ce && s_q.zs == ZS_TIMING && s_q.sec_cnt + 1'b1 < s_q.zs_delay |=> !ce || !zero_speed_disable
	) else $error("disabled before the delay ran out");

	c_ms_eight: cover property (src == `SRC_MS && ms_idx == 3'h7);
	c_zs_timed: cover property (s_q.zs == ZS_TIMING ##1 s_q.zs == ZS_DIS);
	c_zs_wake:  cover property (s_q.zs == ZS_DIS ##1 s_q.zs == ZS_RUN);
	c_ep_top:   cover property (ep_up && s_q.ep_ref == s_q.max_lim);

endmodule : speed_ref_zero

// >>> core/speed_ref_params.svh
// constants for the speed reference selector and zero-speed logic
// assumes 32-bit APB, byte addresses on paddr[7:0]
`ifndef SPEED_REF_PARAMS_SVH
`define SPEED_REF_PARAMS_SVH

`define SPD_W         16
`define N_DIN         5
`define FN_W          5
`define SRC_W         4
`define DELAY_W       10
`define CTRL_W        14
`define TICK_W        24

// register byte addresses
`define A_CTRL        8'h00
`define A_DIN_FUNC    8'h04
`define A_DELAY       8'h08
`define A_THRESH      8'h0C
`define A_LIMITS      8'h10
`define A_EP          8'h14
`define A_WAKE        8'h18
`define A_STATUS      8'h1C
`define A_FIXED_BASE  8'h20
`define A_FIXED_LAST  8'h3C

// control register fields
`define C_LOC         0
`define C_REM         4
`define C_REM_SEL     8
`define C_ZS_MODE     9
`define C_EXIT        11
`define C_REG_SEL     12
`define C_REG_AUTO    13
`define HI_HALF       16

// status register fields
`define S_DRV_EN      16
`define S_ZS_DIS      17
`define S_ZS_TIMING   18

// codes
`define SRC_EP        4'h7
`define SRC_MS        4'h8
`define FN_EP_UP      5'h0B
`define FN_EP_DN      5'h0C
`define FN_MS         5'h0D
`define MODE_OFF      2'h0
`define MODE_BOTH     2'h1
`define MODE_REF      2'h2

// timing
`define CLK_PERIOD_NS 100
`define DELAY_UNIT_NS 1000000000
`define HYST_DIV      16'h0064

// reset values
`define RST_MIN       16'h005A
`define RST_MAX       16'h0708
`define RST_RATED     16'h0708
`define RST_THRESH    16'h0000
`define RST_EP_STEP   16'h0001
`define RST_EP_DIV    16'h03E8
`define RST_FIX0      16'h005A
`define RST_FIX1      16'h012C
`define RST_FIX2      16'h0258
`define RST_FIX3      16'h0384
`define RST_FIX4      16'h04B0
`define RST_FIX5      16'h05DC
`define RST_FIX6      16'h0708
`define RST_FIX7      16'h0672

`endif

// >>> core/speed_ref_pkg.sv
// types for the speed reference selector and zero-speed logic
// assumes speed_ref_params.svh is on the include path
`include "speed_ref_params.svh"
package speed_ref_pkg;

	typedef enum logic [1:0] {
		ZS_RUN    = 2'b00,
		ZS_TIMING = 2'b01,
		ZS_DIS    = 2'b10
	} zs_state_t;

	typedef struct packed {
		logic [`N_DIN-1:0]                din_s1;
		logic [`N_DIN-1:0]                din_s2;
		logic [`CTRL_W-1:0]               ctrl;
		logic [`N_DIN-1:0][`FN_W-1:0]     din_func;
		logic [`DELAY_W-1:0]              zs_delay;
		logic [`SPD_W-1:0]                thresh;
		logic [`SPD_W-1:0]                rated;
		logic [`SPD_W-1:0]                min_lim;
		logic [`SPD_W-1:0]                max_lim;
		logic [`SPD_W-1:0]                ep_step;
		logic [`SPD_W-1:0]                ep_div;
		logic [`SPD_W-1:0]                ep_cnt;
		logic [`SPD_W-1:0]                wake;
		logic [7:0][`SPD_W-1:0]           fixed;
		logic [`SPD_W-1:0]                ep_ref;
		logic [`SPD_W-1:0]                spd_ref;
		zs_state_t                        zs;
		logic [`TICK_W-1:0]               tick_cnt;
		logic [`DELAY_W-1:0]              sec_cnt;
		logic                             drv_en;
		logic                             zs_dis;
		logic                             pready;
		logic                             pslverr;
		logic [31:0]                      prdata;
	} state_t;

endpackage : speed_ref_pkg

// >>> dv/din_switches.sv
// external switch model driving the isolated digital inputs
// assumes the bench sets wanted levels just after rising edges of pclk
`timescale 1ns/1ps
`include "speed_ref_params.svh"
module din_switches (
	// clock
	input  wire logic              pclk,
	// wanted switch levels
	input  wire logic [2:0]        sel,
	input  wire logic              up,
	input  wire logic              dn,
	// isolated inputs
	output logic      [`N_DIN-1:0] din
);
	initial din = '0;
	// one register stage for the whole vector, so several levels can change on the same edge
	always @(posedge pclk) begin
		din <= {dn, up, sel};
	end
endmodule : din_switches

// >>> dv/speed_reference_select_zero_speed_tb.sv
// self-checking bench: registers, multispeed, e-pot and zero-speed disable
// assumes the design package and params header are compiled first
`timescale 1ns/1ps
`include "speed_ref_params.svh"
module speed_reference_select_zero_speed_tb;
	localparam int TK = 10;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic              run, up, dn, drv, zsd;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata;
	logic [2:0]        sel;
	logic [`N_DIN-1:0] din;
	logic [15:0]       act, sref, oref, rerr;
	logic [15:0]       fx[8];
	logic [32:0]       q[$];
	int                num_errors, n_checks, i, off;

	speed_ref_zero #(.TICK_CYCLES(TK)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .din(din), .drive_run_cmd(run), .ref_other(oref), .actual_speed_value(act),
		.regulator_error(rerr), .speed_ref_value(sref), .drive_enable(drv), .zero_speed_disable(zsd));
	din_switches u_sw (.pclk(pclk), .sel(sel), .up(up), .dn(dn), .din(din));

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask : chk

	task automatic results();
		if (num_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// entered just after a rising edge; read expectations go to the queue
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		if (!w) q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// pready is looked at as it stands at the rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk(1'b0, "bus timeout");
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_ref(input logic [15:0] v, input int lim);
		int n;
		for (n = 0; n < lim && sref !== v; n++) @(negedge pclk);
		chk(sref === v, "speed reference");
		@(posedge pclk);
	endtask : wait_ref

	task automatic wait_zs(input logic b, input int lim);
		int n;
		for (n = 0; n < lim && zsd !== b; n++) @(negedge pclk);
		chk(zsd === b && drv === !b, "zero speed state");
		@(posedge pclk);
	endtask : wait_zs

	task automatic hold_zs(input logic b, input int lim);
		logic ok;
		ok = 1'b1;
		repeat (lim) begin
			@(negedge pclk);
			if (zsd !== b) ok = 1'b0;
		end
		chk(ok, "zero speed held");
		@(posedge pclk);
	endtask : hold_zs

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// read data taken at the access edge where pready is high
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk({pslverr, prdata} === q.pop_front(), "read data");
		end
	end

	initial begin
		repeat (100000) @(posedge pclk);
		chk(1'b0, "run timeout");
		results();
	end

	initial begin
		num_errors = 0;
		n_checks = 0;
		{presetn, psel, penable, pwrite, run, up} = 6'h00;
		{paddr, pwdata, sel, act, oref, rerr} = '0;
		dn = 1'b1;
		fx = '{`RST_FIX0, `RST_FIX1, `RST_FIX2, `RST_FIX3, `RST_FIX4, `RST_FIX5, `RST_FIX6, `RST_FIX7};
		void'($urandom(97));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 8; i++) apb(1'b0, 8'(8'h20 + 4 * i), '0, {17'h00000, fx[i]});
		apb(1'b0, `A_LIMITS, '0, {1'b0, `RST_MAX, `RST_MIN});
		apb(1'b0, `A_CTRL, '0, 33'h000000000);
		apb(1'b1, 8'h40, 32'hFFFFFFFF, '0);
		apb(1'b0, 8'h40, '0, 33'h100000000);
		fx[3] = 16'($urandom_range(1800, 100));
		apb(1'b1, 8'h2C, {16'h0000, fx[3]}, '0);
		apb(1'b1, `A_DIN_FUNC, 32'h00C5B5AD, '0);
		apb(1'b1, `A_CTRL, 32'h00000008, '0);
		off = $urandom_range(7, 0);
		for (i = 0; i < 8; i++) begin
			sel <= 3'(i + off);
			@(posedge pclk);
			wait_ref(fx[3'(i + off)], 10);
		end
		apb(1'b1, `A_DIN_FUNC, 32'h00C581A0, '0);
		sel <= 3'h7;
		@(posedge pclk);
		wait_ref(fx[2], 10);
		oref <= 16'($urandom_range(1800, 1000));
		apb(1'b1, `A_CTRL, 32'h00000081, '0);
		wait_ref(oref, 10);
		apb(1'b1, `A_CTRL, 32'h00000181, '0);
		wait_ref(fx[2], 10);
		apb(1'b1, `A_CTRL, 32'h00000008, '0);
		apb(1'b1, 8'h20, 32'h00000010, '0);
		run <= 1'b1;
		sel <= 3'h1;
		@(posedge pclk);
		wait_ref(`RST_MIN, 10);
		// threshold 500, hysteresis 18
		apb(1'b1, `A_THRESH, 32'h070801F4, '0);
		apb(1'b1, `A_CTRL, 32'h00000408, '0);
		sel <= 3'h0;
		@(posedge pclk);
		wait_zs(1'b1, 10);
		sel <= 3'h2;
		@(posedge pclk);
		wait_zs(1'b0, 10);
		apb(1'b1, `A_CTRL, 32'h00000A08, '0);
		act <= 16'h03E8;
		sel <= 3'h0;
		@(posedge pclk);
		hold_zs(1'b0, 10);
		act <= 16'h0000;
		@(posedge pclk);
		wait_zs(1'b1, 10);
		act <= 16'h03E8;
		@(posedge pclk);
		hold_zs(1'b1, 10);
		apb(1'b1, `A_CTRL, 32'h00000208, '0);
		wait_zs(1'b0, 10);
		apb(1'b1, `A_CTRL, 32'h00003408, '0);
		wait_zs(1'b1, 10);
		sel <= 3'h2;
		@(posedge pclk);
		hold_zs(1'b1, 10);
		rerr <= 16'($urandom_range(1000, 1));
		@(posedge pclk);
		wait_zs(1'b0, 10);
		sel <= 3'h2;
		apb(1'b1, `A_DELAY, 32'h00000002, '0);
		apb(1'b1, `A_CTRL, 32'h00000408, '0);
		sel <= 3'h0;
		@(posedge pclk);
		hold_zs(1'b0, 2 * TK);
		wait_zs(1'b1, 10);
		sel <= 3'h2;
		@(posedge pclk);
		wait_zs(1'b0, 10);
		sel <= 3'h0;
		repeat (8) @(posedge pclk);
		sel <= 3'h2;
		hold_zs(1'b0, 40);
		apb(1'b1, `A_EP, 32'h00010100, '0);
		apb(1'b1, `A_CTRL, 32'h00000007, '0);
		up <= 1'b1;
		@(posedge pclk);
		wait_ref(`RST_MAX, 100);
		up <= 1'b0;
		dn <= 1'b0;
		@(posedge pclk);
		wait_ref(`RST_MIN, 100);
		up <= 1'b1;
		dn <= 1'b1;
		repeat (12) @(posedge pclk);
		run <= 1'b0;
		dn <= 1'b0;
		@(posedge pclk);
		wait_ref(`RST_MIN, 6);
		apb(1'b1, `A_STATUS, 32'hFFFFFFFF, '0);
		apb(1'b0, `A_STATUS, '0, {17'h00000, `RST_MIN});
		results();
	end
endmodule : speed_reference_select_zero_speed_tb
